/* rtl/ccx_exec.sv */
// Purpose: executes clear-file, clear-watchdog, complement and
//          compare-skip-if-equal on an 8-bit file
// Assumes: one instruction issued per write to the instruction register
// Notes:   file memory is flip-flops; postscaler counts free each clock, watchdog counter on each postscaler wrap
`timescale 1ns/1ps
module ccx_exec #(
  parameter int ADDR_W = 12,
  parameter int WDOG_W = 8,
  parameter int POST_W = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int MEM_N = 1 << ADDR_W;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                   aw_got;
    logic [7:0]             aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   ext_en;
    logic                   next_two;
    logic [ADDR_W-1:0]      ilo_base;
    logic [7:0]             work;
    logic [3:0]             bank;
    logic [7:0]             status;
    logic [WDOG_W-1:0]      wdog;
    logic [POST_W-1:0]      post;
    logic [15:0]            instr;
    logic [15:0]            pc;
    logic [1:0]             cycles;
    ccx_pkg::ccx_state_t    state;
    logic [MEM_N-1:0][7:0]  mem;
  } ccx_regs_t;

  ccx_regs_t r;
  ccx_regs_t next_r;

  // effective file address from operand, access bit and bank
  function automatic logic [ADDR_W-1:0] eff_addr(
    input logic [15:0]       ins,
    input logic              ext,
    input logic [3:0]        bank_select_reg,
    input logic [ADDR_W-1:0] base
  );
    logic [7:0] f;
    f = ins[7:0];
    if (ins[ccx_pkg::A_BIT]) begin
      eff_addr = ADDR_W'({bank_select_reg, f});
    end else if (ext && f <= ccx_pkg::ILO_LIMIT) begin
      eff_addr = base + ADDR_W'(f);
    end else if (f[7]) begin
      eff_addr = ADDR_W'({4'hf, f});
    end else begin
      eff_addr = ADDR_W'(f);
    end
  endfunction : eff_addr

  logic              wr_fire;
  logic              rd_fire;
  logic [ADDR_W-1:0] ea;
  logic [7:0]        fval;
  logic [8:0]        diff;
  logic              is_clear_file_op;
  logic              is_clrwdog;
  logic              is_complement_file_op;
  logic              is_cpseq;

  // ****************************************
  // decode and execution
  // ****************************************
  always_comb begin
    next_r = r;
    wr_fire = r.aw_got && r.w_got && !r.bvalid;
    rd_fire = s_axi_arvalid && !r.rvalid;
    ea = eff_addr(r.instr, r.ext_en, r.bank, r.ilo_base);
    fval = r.mem[ea];
    diff = {1'b0, fval} - {1'b0, r.work};
    is_clear_file_op = 1'b0;
    is_clrwdog = 1'b0;
    is_complement_file_op = 1'b0;
    is_cpseq = 1'b0;
    {next_r.wdog, next_r.post} = {r.wdog, r.post} + 1'b1;
    if (s_axi_awvalid && !r.aw_got) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got) begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (s_axi_bready && r.bvalid) begin
      next_r.bvalid = 1'b0;
    end
    if (s_axi_rready && r.rvalid) begin
      next_r.rvalid = 1'b0;
    end
    if (wr_fire) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = ccx_pkg::RESP_OKAY;
      case (r.aw_addr)
        ccx_pkg::OFF_CTRL: begin
          next_r.ext_en = r.w_data[0];
          next_r.next_two = r.w_data[1];
          next_r.ilo_base = r.w_data[16 +: ADDR_W];
        end
        ccx_pkg::OFF_INSTR: begin
          next_r.instr = r.w_data[15:0];
          next_r.pc = r.pc + 16'h0002;
          next_r.cycles = 2'h1;
          if (r.state != ccx_pkg::S_IDLE) begin
            // squashed slot: pc, instr, cycles and skip state update; nothing executes
            next_r.state = (r.state == ccx_pkg::S_SKIP2) ?
                           ccx_pkg::S_SKIP1 : ccx_pkg::S_IDLE;
            next_r.cycles = 2'h0;
          end else begin
            ea = eff_addr(r.w_data[15:0], r.ext_en, r.bank,
                          r.ilo_base);
            fval = r.mem[ea];
            diff = {1'b0, fval} - {1'b0, r.work};
            is_clear_file_op = r.w_data[15:9] == ccx_pkg::OP_CLEAR_FILE_OP_HI;
            is_clrwdog = r.w_data[15:0] == ccx_pkg::OP_CLRWDOG;
            is_complement_file_op = r.w_data[15:10] == ccx_pkg::OP_COMPLEMENT_FILE_OP_HI;
            is_cpseq = r.w_data[15:9] == ccx_pkg::OP_CPSEQ_HI;
          end
        end
        ccx_pkg::OFF_NEXT:   next_r.next_two = r.w_data[0];
        ccx_pkg::OFF_WORK:   next_r.work = r.w_data[7:0];
        ccx_pkg::OFF_BANK:   next_r.bank = r.w_data[3:0];
        ccx_pkg::OFF_STATUS: next_r.status = r.w_data[7:0];
        default:             next_r.bresp = ccx_pkg::RESP_SLVERR;
      endcase
    end
    if (is_clear_file_op) begin
      next_r.mem[ea] = 8'h00;
      next_r.status[ccx_pkg::ST_Z] = 1'b1;
    end
    if (is_clrwdog) begin
      next_r.wdog = '0;
      next_r.post = '0;
      next_r.status[ccx_pkg::ST_TO] = 1'b1;
      next_r.status[ccx_pkg::ST_PD] = 1'b1;
    end
    if (is_complement_file_op) begin
      if (r.w_data[ccx_pkg::D_BIT]) begin
        next_r.mem[ea] = ~fval;
      end else begin
        next_r.work = ~fval;
      end
      next_r.status[ccx_pkg::ST_Z] = (fval == 8'hff);
      next_r.status[ccx_pkg::ST_N] = ~fval[7];
    end
    if (is_cpseq && diff == 9'h000) begin
      // status untouched: only the skip sequencer reacts
      next_r.state = r.next_two ? ccx_pkg::S_SKIP2 :
                     ccx_pkg::S_SKIP1;
      next_r.cycles = r.next_two ? 2'h3 : 2'h2;
    end
    if (rd_fire) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = ccx_pkg::RESP_OKAY;
      next_r.rdata = 32'h00000000;
      case (s_axi_araddr)
        ccx_pkg::OFF_CTRL:   next_r.rdata = 32'({r.ilo_base, 16'h0000})
                                            | {30'h0, r.next_two, r.ext_en};
        ccx_pkg::OFF_INSTR:  next_r.rdata = {r.pc, r.instr};
        ccx_pkg::OFF_NEXT:   next_r.rdata = {30'h0, r.cycles};
        ccx_pkg::OFF_WORK:   next_r.rdata = {24'h0, r.work};
        ccx_pkg::OFF_BANK:   next_r.rdata = {28'h0, r.bank};
        ccx_pkg::OFF_STATUS: next_r.rdata = {22'h0, r.state, r.status};
        ccx_pkg::OFF_WDOG:   next_r.rdata = 32'({r.post, r.wdog});
        default:             next_r.rresp = ccx_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.status <= ccx_pkg::STATUS_RST;
      r.state <= ccx_pkg::S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = !r.aw_got;
  assign s_axi_wready  = !r.w_got;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;

  // ****************************************
  // checks
  // ****************************************
  logic instr_wr;
  assign instr_wr = wr_fire && r.aw_addr == ccx_pkg::OFF_INSTR;

  AST_WDOG_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    is_clrwdog |=> r.wdog == '0 && r.post == '0)
    else $error("watchdog not cleared");
  AST_WDOG_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    is_clrwdog |=> r.status[ccx_pkg::ST_TO] && r.status[ccx_pkg::ST_PD]
      && r.status[2:0] == $past(r.status[2:0]))
    else $error("clear watchdog flags wrong");
  AST_OPC: assert property (@(posedge aclk) disable iff (!aresetn)
    instr_wr && r.state == ccx_pkg::S_IDLE && r.w_data[15:0] == 16'h0004
      |-> is_clrwdog)
    else $error("clear watchdog not decoded");
  AST_COMPLEMENT_FILE_OP_W: assert property (@(posedge aclk) disable iff (!aresetn)
    is_complement_file_op && !r.w_data[ccx_pkg::D_BIT] |=> r.work == ~$past(fval))
    else $error("complement to working reg wrong");
  AST_CPSEQ_NOFLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    is_cpseq |=> r.status == $past(r.status) && r.work == $past(r.work))
    else $error("compare altered state");
  AST_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
    is_cpseq && diff == 9'h000 && !r.next_two |=> r.cycles == 2'h2
      && r.state == ccx_pkg::S_SKIP1)
    else $error("skip not taken");
  AST_SKIP2: assert property (@(posedge aclk) disable iff (!aresetn)
    is_cpseq && diff == 9'h000 && r.next_two |=> r.cycles == 2'h3
      && r.state == ccx_pkg::S_SKIP2)
    else $error("two-word skip wrong");
  AST_CLEAR_FILE_OP: assert property (@(posedge aclk) disable iff (!aresetn)
    is_clear_file_op |=> r.status[ccx_pkg::ST_Z] && r.mem[$past(ea)] == 8'h00)
    else $error("clear file wrong");
  AST_SQUASH: assert property (@(posedge aclk) disable iff (!aresetn)
    instr_wr && r.state != ccx_pkg::S_IDLE |=> r.work == $past(r.work)
      && r.status == $past(r.status) && r.pc == $past(r.pc) + 16'h0002)
    else $error("squashed slot had effect");
  AST_ILO: assert property (@(posedge aclk) disable iff (!aresetn)
    instr_wr && r.state == ccx_pkg::S_IDLE && !r.w_data[ccx_pkg::A_BIT]
      && r.ext_en && r.w_data[7:0] <= ccx_pkg::ILO_LIMIT
      |-> ea == r.ilo_base + ADDR_W'(r.w_data[7:0]))
    else $error("indexed address wrong");
  AST_BANK: assert property (@(posedge aclk) disable iff (!aresetn)
    instr_wr && r.state == ccx_pkg::S_IDLE && r.w_data[ccx_pkg::A_BIT]
      |-> ea == ADDR_W'({r.bank, r.w_data[7:0]}))
    else $error("banked address wrong");

  COV_CLRWDOG: cover property (@(posedge aclk) is_clrwdog);
  COV_SKIP1: cover property (@(posedge aclk)
    is_cpseq && diff == 9'h000 && !r.next_two);
  COV_SKIP2: cover property (@(posedge aclk)
    is_cpseq && diff == 9'h000 && r.next_two);
  COV_COMPLEMENT_FILE_OP_F: cover property (@(posedge aclk)
    is_complement_file_op && r.w_data[ccx_pkg::D_BIT]);
endmodule : ccx_exec

/* rtl/ccx_pkg.sv */
// Purpose: shared constants for the clear/complement/compare execution block
// Assumes: 16-bit instruction words, 8-bit data path, axi4-lite control
// Notes:   offsets are byte addresses of 32-bit registers
package ccx_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [15:0] OP_CLRWDOG      = 16'h0004;
  localparam logic [6:0]  OP_CLEAR_FILE_OP_HI      = 7'h35;   // 0110 101a
  localparam logic [5:0]  OP_COMPLEMENT_FILE_OP_HI      = 6'h07;   // 0001 11da
  localparam logic [6:0]  OP_CPSEQ_HI     = 7'h31;   // 0110 001a
  localparam logic [7:0]  ILO_LIMIT       = 8'h5f;
  localparam int          A_BIT           = 8;
  localparam int          D_BIT           = 9;
  // ****************************************
  // registers
  // ****************************************
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_INSTR       = 8'h04;
  localparam logic [7:0]  OFF_NEXT        = 8'h08;
  localparam logic [7:0]  OFF_WORK        = 8'h0c;
  localparam logic [7:0]  OFF_BANK        = 8'h10;
  localparam logic [7:0]  OFF_STATUS      = 8'h14;
  localparam logic [7:0]  OFF_WDOG        = 8'h18;
  localparam int          ST_Z            = 2;
  localparam int          ST_PD           = 3;
  localparam int          ST_TO           = 4;
  localparam int          ST_N            = 7;
  localparam logic [7:0]  STATUS_RST      = 8'h18;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  typedef enum logic [1:0] {S_IDLE, S_SKIP1, S_SKIP2} ccx_state_t;
endpackage : ccx_pkg

/* verification/ccx_exec_tb_top.sv */
// Purpose: random and corner-case bench for the ccx_exec block
// Assumes: file memory and pc reset to zero; register map as handed over
// Notes:   a byte model of the whole file tracks every op that is not squashed
`timescale 1ns/1ps
module ccx_exec_tb_top;
  // ****************************************
  // signals and model state
  // ****************************************
  logic        aclk        = 1'b0;
  logic        aresetn     = 1'b0;
  logic [7:0]  awaddr      = 8'h00;
  logic        awvalid     = 1'b0;
  logic        awready;
  logic [31:0] wdata       = 32'h0;
  logic        wvalid      = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready      = 1'b0;
  logic [7:0]  araddr      = 8'h00;
  logic        arvalid     = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready      = 1'b0;
  logic [31:0] seed        = 32'h812b2960;
  logic [7:0]  mem [4096];
  logic [7:0]  w_m         = 8'h00;
  logic        z_m         = 1'b0;
  logic        n_m         = 1'b0;
  logic [1:0]  sk_m        = 2'd0;
  logic [15:0] pc_m        = 16'h0;
  logic [3:0]  bank_m      = 4'h0;
  logic        ext_m       = 1'b0;
  logic [11:0] base_m      = 12'h0;
  int          fails       = 0;
  int          check_count = 0;

  always #10 aclk = ~aclk;

  ccx_exec i_ccx_exec (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // a hung handshake is a mismatch and ends the run
  task automatic tmo(input int n);
    if (n >= 100) begin
      fails++;
      summarize();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask : rd

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [11:0] ea_f(logic [7:0] f, logic a);
    if (a) return {bank_m, f};
    if (ext_m && f <= ccx_pkg::ILO_LIMIT) return base_m + {4'h0, f};
    return f[7] ? {4'hf, f} : {4'h0, f};
  endfunction : ea_f

  // watchdog is read first: the postscaler steps every clock and the
  // counter on each postscaler wrap, so the bound is loose
  task automatic exec_chk(input logic [15:0] ins, input logic [31:0] cyc,
                          input logic wd);
    logic [31:0] d;
    logic [1:0]  r;
    wr(ccx_pkg::OFF_INSTR, {16'h0, ins}, r);
    chk({30'h0, r}, {30'h0, ccx_pkg::RESP_OKAY});
    pc_m += 16'h2;
    if (wd) begin
      rd(ccx_pkg::OFF_WDOG, d, r);
      // read-back is {postscaler, counter}: counter must be back at zero
      chk({31'h0, {d[7:0], d[15:8]} < 16'h000c}, 32'h1);
    end
    rd(ccx_pkg::OFF_WORK, d, r);
    chk(d, {24'h0, w_m});
    chk({30'h0, r}, {30'h0, ccx_pkg::RESP_OKAY});
    rd(ccx_pkg::OFF_STATUS, d, r);
    chk(d, {22'h0, sk_m, n_m, 2'b00, 2'b11, z_m, 2'b00});
    rd(ccx_pkg::OFF_NEXT, d, r);
    chk(d, cyc);
    rd(ccx_pkg::OFF_INSTR, d, r);
    chk({16'h0, d[31:16]}, {16'h0, pc_m});
  endtask : exec_chk

  // ****************************************
  // main sequence
  // ****************************************
  initial begin : main
    logic [31:0] rnd, d, cyc;
    logic [15:0] ins;
    logic [11:0] ea;
    logic [7:0]  f, res;
    logic [1:0]  r, op;
    logic        a, tw;
    int          i;
    for (i = 0; i < 4096; i++) mem[i] = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ccx_pkg::OFF_STATUS, d, r);
    chk(d, 32'h18);
    wr(8'h1c, 32'h1, r);
    chk({30'h0, r}, {30'h0, ccx_pkg::RESP_SLVERR});
    rd(8'h1c, d, r);
    chk({30'h0, r}, {30'h0, ccx_pkg::RESP_SLVERR});
    // long wait first so the watchdog counter has moved off zero
    repeat (600) @(posedge aclk);
    exec_chk(ccx_pkg::OP_CLRWDOG, 32'h1, 1'b1);
    for (i = 0; i < 60; i++) begin
      rnd    = xs();
      op     = (i < 2) ? 2'd1 : rnd[1:0];
      a      = (i < 2) ? 1'b0 : rnd[2];
      ext_m  = (i < 2) | rnd[4];
      f      = (i < 2) ? 8'h5f + 8'(i) : rnd[15:8];
      bank_m = rnd[19:16];
      base_m = rnd[31:20];
      tw     = rnd[5];
      wr(ccx_pkg::OFF_CTRL, {4'h0, base_m, 15'h0, ext_m}, r);
      rd(ccx_pkg::OFF_CTRL, d, r);
      chk(d, {4'h0, base_m, 15'h0, ext_m});
      wr(ccx_pkg::OFF_BANK, {28'h0, bank_m}, r);
      wr(ccx_pkg::OFF_NEXT, {31'h0, tw}, r);
      ea  = ea_f(f, a);
      w_m = rnd[6] ? mem[ea] : rnd[27:20];
      wr(ccx_pkg::OFF_WORK, {24'h0, w_m}, r);
      cyc = 32'h1;
      case (op)
        2'd0: begin
          mem[ea] = 8'h00;
          z_m     = 1'b1;
          ins     = {ccx_pkg::OP_CLEAR_FILE_OP_HI, a, f};
        end
        2'd1: begin
          res = ~mem[ea];
          if (rnd[3]) mem[ea] = res;
          else w_m = res;
          z_m = (res == 8'h00);
          n_m = res[7];
          ins = {ccx_pkg::OP_COMPLEMENT_FILE_OP_HI, rnd[3], a, f};
        end
        2'd2: begin
          if (mem[ea] == w_m) begin
            sk_m = tw ? 2'd2 : 2'd1;
            cyc  = tw ? 32'h3 : 32'h2;
          end
          ins = {ccx_pkg::OP_CPSEQ_HI, a, f};
        end
        default: ins = ccx_pkg::OP_CLRWDOG;
      endcase
      exec_chk(ins, cyc, op == 2'd3);
      // squashed words would invert a file byte if they ran
      while (sk_m != 2'd0) begin
        sk_m--;
        exec_chk({ccx_pkg::OP_COMPLEMENT_FILE_OP_HI, 1'b1, rnd[12:4]}, 32'h0, 1'b0);
      end
    end
    summarize();
  end : main
endmodule : ccx_exec_tb_top
